// *** hdl/osm_oscillator_mode_select.sv ***
// Oscillator mode decode, pin role control, clock output and multiplier control
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Ten modes chosen by four-bit field.
// - Crystal modes run amplifier across both pins.
// - External clock modes skip start-up delay.
// - External divided mode drives clock/4 out.
// - External pin mode: output pin is bit6.
// - RC clock-output mode drives clock/4 out.
// - RC pin mode: output pin is bit6.
// - Internal clock-output: bit6 clock/4, bit7 free.
// - Internal dual-pin mode frees bits six, seven.
// - Fast crystal mode accepts external clock.
// - Multiplied crystal: 10 MHz times four.
// - Multiplied crystal hides software multiplier enable.
// - Crystal multiplier only for code 0110.
// - Internal source allows software multiplier enable.
// - Internal multiplier needs 1001/1000 and 111/110.
module osm_oscillator_mode_select #(
   parameter logic [3:0] CODE_LOW_POWER = 4'h0,
   parameter logic [3:0] CODE_STANDARD = 4'h1,
   parameter logic [3:0] CODE_FAST = 4'h2,
   parameter logic [3:0] CODE_RC_CLKOUT = 4'h3,
   parameter logic [3:0] CODE_EXT_DIVOUT = 4'h4,
   parameter logic [3:0] CODE_EXT_PIN = 4'h5,
   parameter logic [3:0] CODE_RC_PIN = 4'h7,
   parameter int START_CYCLES = 1024,
   parameter int START_W = 11
) (
   // Clock, reset and freeze
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Nonvolatile mode select field
   input wire logic [3:0] mode_cfg,
   // Same-clock controls
   input wire logic [2:0] internal_freq_select,
   input wire logic mult_en_wr,
   input wire logic mult_en_wdata,
   input wire logic wake,
   // Port bit six and seven drive from the port logic
   input wire logic gpio6_out,
   input wire logic gpio6_oe_n,
   input wire logic gpio7_out,
   input wire logic gpio7_oe_n,
   // Oscillator pins
   input wire logic osc_in_pin_i,
   input wire logic osc_out_pin_i,
   output logic osc_in_pin_o,
   output logic osc_in_pin_oe_n,
   output logic osc_out_pin_o,
   output logic osc_out_pin_oe_n,
   // Port bit six and seven read back
   output logic gpio6_in,
   output logic gpio7_in,
   // Clock control state
   output osm_pkg::osm_mode_e mode,
   output logic mode_valid,
   output logic amp_enable,
   output logic clk_ready,
   output logic xtal_mult_on,
   output logic int_mult_on,
   output logic multiplier_enable_bit
);

   // Map a raw field value onto a mode; unknown codes fall back to RC output
   function automatic osm_pkg::osm_mode_e decode_mode(input logic [3:0] code);
      osm_pkg::osm_mode_e m;
      m = osm_pkg::MODE_RST;
      if (code == osm_pkg::CODE_FAST_MULT) m = osm_pkg::fast_crystal_multiplied_mode;
      else if (code == osm_pkg::CODE_INT_CLKOUT) m = osm_pkg::internal_osc_clkout_mode;
      else if (code == osm_pkg::CODE_INT_DUAL) m = osm_pkg::internal_osc_dual_pin_mode;
      else if (code == CODE_LOW_POWER) m = osm_pkg::low_power_crystal_mode;
      else if (code == CODE_STANDARD) m = osm_pkg::standard_crystal_mode;
      else if (code == CODE_FAST) m = osm_pkg::fast_crystal_mode;
      else if (code == CODE_RC_CLKOUT) m = osm_pkg::resistor_capacitor_clkout_mode;
      else if (code == CODE_RC_PIN) m = osm_pkg::resistor_capacitor_pin_mode;
      else if (code == CODE_EXT_DIVOUT) m = osm_pkg::external_clock_divout_mode;
      else if (code == CODE_EXT_PIN) m = osm_pkg::external_clock_pin_mode;
      return m;
   endfunction : decode_mode

   // Pin roles of each mode
   function automatic osm_pkg::osm_role_s role_of(input osm_pkg::osm_mode_e m);
      osm_pkg::osm_role_s r;
      r = '0;
      unique case (m)
         osm_pkg::low_power_crystal_mode,
         osm_pkg::standard_crystal_mode,
         osm_pkg::fast_crystal_mode,
         osm_pkg::fast_crystal_multiplied_mode: begin
            r.amp_on = 1'b1;
            r.needs_start = 1'b1;
         end
         osm_pkg::resistor_capacitor_clkout_mode: r.clkout = 1'b1;
         osm_pkg::resistor_capacitor_pin_mode: r.out_gpio = 1'b1;
         osm_pkg::internal_osc_clkout_mode: begin
            r.clkout = 1'b1;
            r.in_gpio = 1'b1;
            r.internal_src = 1'b1;
         end
         osm_pkg::internal_osc_dual_pin_mode: begin
            r.out_gpio = 1'b1;
            r.in_gpio = 1'b1;
            r.internal_src = 1'b1;
         end
         osm_pkg::external_clock_divout_mode: r.clkout = 1'b1;
         osm_pkg::external_clock_pin_mode: r.out_gpio = 1'b1;
      endcase
      return r;
   endfunction : role_of

   logic [3:0] cfg_sync1_r;
   logic [3:0] cfg_sync2_r;
   logic [1:0] cap_cnt_r;
   logic cap_done_r;
   osm_pkg::osm_mode_e mode_r;
   osm_pkg::osm_role_s role;
   logic [osm_pkg::DIV_W-1:0] div_cnt_r;
   logic [START_W-1:0] start_cnt_r;
   logic ready_r;
   logic mult_en_r;
   logic freq_ok;
   logic in_sync1_r;
   logic in_sync2_r;
   logic out_sync1_r;
   logic out_sync2_r;

   assign role = role_of(mode_r);
   assign freq_ok = (internal_freq_select == osm_pkg::FREQ_MULT_HI) ||
                    (internal_freq_select == osm_pkg::FREQ_MULT_LO);

   // Field comes from fuses outside this clock, so it is synchronised first
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_sync1_r <= osm_pkg::CFG_RST;
         cfg_sync2_r <= osm_pkg::CFG_RST;
      end else if (clk_en) begin
         cfg_sync1_r <= mode_cfg;
         cfg_sync2_r <= cfg_sync1_r;
      end
   end

   // Take the field once after release and hold it until the next reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cap_cnt_r <= 2'h0;
         cap_done_r <= 1'b0;
         mode_r <= osm_pkg::MODE_RST;
      end else if (clk_en && !cap_done_r) begin
         if (cap_cnt_r == osm_pkg::CAP_DELAY) begin
            mode_r <= decode_mode(cfg_sync2_r);
            cap_done_r <= 1'b1;
         end else begin
            cap_cnt_r <= cap_cnt_r + 2'h1;
         end
      end
   end

   // Free-running divider; its top bit is the clock/4 output
   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_cnt_r <= '0;
      end else if (clk_en) begin
         div_cnt_r <= div_cnt_r + 2'h1;
      end
   end

   // Start-up wait after reset or wake; only crystal modes wait
   always_ff @(posedge core_clk) begin
      if (rst) begin
         start_cnt_r <= '0;
         ready_r <= 1'b0;
      end else if (clk_en) begin
         if (!cap_done_r || wake) begin
            start_cnt_r <= '0;
            ready_r <= 1'b0;
         end else if (!role.needs_start) begin
            ready_r <= 1'b1;
         end else if (start_cnt_r == START_W'(START_CYCLES - 1)) begin
            ready_r <= 1'b1;
         end else if (!ready_r) begin
            start_cnt_r <= start_cnt_r + START_W'(1);
         end
      end
   end

   // Software multiplier enable; writes ignored unless internal source at 4 or 8 MHz
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mult_en_r <= 1'b0;
      end else if (clk_en) begin
         if (!(role.internal_src && freq_ok)) begin
            mult_en_r <= 1'b0;
         end else if (mult_en_wr) begin
            mult_en_r <= mult_en_wdata;
         end
      end
   end

   // Pins read back as port bits pass three flops, two here and one at the status outputs
   always_ff @(posedge core_clk) begin
      if (rst) begin
         in_sync1_r <= 1'b0;
         in_sync2_r <= 1'b0;
         out_sync1_r <= 1'b0;
         out_sync2_r <= 1'b0;
      end else if (clk_en) begin
         in_sync1_r <= osc_in_pin_i;
         in_sync2_r <= in_sync1_r;
         out_sync1_r <= osc_out_pin_i;
         out_sync2_r <= out_sync1_r;
      end
   end

   // Registered pin drive; port data reaches the pins one cycle late
   always_ff @(posedge core_clk) begin
      if (rst) begin
         osc_out_pin_o <= 1'b0;
         osc_out_pin_oe_n <= 1'b1;
         osc_in_pin_o <= 1'b0;
         osc_in_pin_oe_n <= 1'b1;
      end else if (clk_en) begin
         if (role.clkout) begin
            osc_out_pin_o <= div_cnt_r[osm_pkg::DIV_W-1];
            osc_out_pin_oe_n <= 1'b0;
         end else if (role.out_gpio) begin
            osc_out_pin_o <= gpio6_out;
            osc_out_pin_oe_n <= gpio6_oe_n;
         end else begin
            osc_out_pin_o <= 1'b0; // Only crystal modes reach here; the amplifier owns the pin
            osc_out_pin_oe_n <= 1'b1;
         end
         osc_in_pin_o <= role.in_gpio ? gpio7_out : 1'b0;
         osc_in_pin_oe_n <= role.in_gpio ? gpio7_oe_n : 1'b1;
      end
   end

   // Status outputs, all from flops
   always_ff @(posedge core_clk) begin
      if (rst) begin
         gpio6_in <= 1'b0;
         gpio7_in <= 1'b0;
         mode <= osm_pkg::MODE_RST;
         mode_valid <= 1'b0;
         amp_enable <= 1'b0;
         clk_ready <= 1'b0;
         xtal_mult_on <= 1'b0;
         int_mult_on <= 1'b0;
         multiplier_enable_bit <= 1'b0;
      end else if (clk_en) begin
         gpio6_in <= role.out_gpio ? out_sync2_r : 1'b0;
         gpio7_in <= role.in_gpio ? in_sync2_r : 1'b0;
         mode <= mode_r;
         mode_valid <= cap_done_r;
         amp_enable <= cap_done_r && role.amp_on;
         clk_ready <= ready_r;
         xtal_mult_on <= cap_done_r && (mode_r == osm_pkg::fast_crystal_multiplied_mode);
         int_mult_on <= mult_en_r && role.internal_src && freq_ok;
         multiplier_enable_bit <= mult_en_r;
      end
   end

   // Checks on held mode, pins and multiplier
   property mode_held_p;
      @(posedge core_clk) disable iff (rst || !clk_en)
         mode_valid |=> mode_valid && $stable(mode);
   endproperty
   mode_hold_a: assert property (mode_held_p) else $error("mode changed after capture");

   ten_modes_a: assert property (@(posedge core_clk) disable iff (rst)
      mode_valid |-> (mode <= osm_pkg::external_clock_pin_mode))
      else $error("mode outside the ten modes");

   crystal_amp_a: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      mode_valid |-> amp_enable == (mode inside {osm_pkg::low_power_crystal_mode,
         osm_pkg::standard_crystal_mode, osm_pkg::fast_crystal_mode,
         osm_pkg::fast_crystal_multiplied_mode}))
      else $error("amplifier does not match crystal mode");

   ext_no_wait_a: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      ($rose(mode_valid) && mode inside {osm_pkg::external_clock_divout_mode,
         osm_pkg::external_clock_pin_mode}) |-> ##1 clk_ready)
      else $error("external clock mode waited for start-up");

   clkout_period_a: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      (mode_valid && role.clkout && $rose(osc_out_pin_o)) |->
         osc_out_pin_o [*2] ##1 !osc_out_pin_o [*2] ##1 osc_out_pin_o)
      else $error("clock output is not device clock over four");

   pin_gpio_a: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      (mode_valid && role.out_gpio) |=> osc_out_pin_oe_n == $past(gpio6_oe_n))
      else $error("output pin not handed to port bit six");

   bit7_gpio_a: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      (mode_valid && !role.in_gpio) |=> osc_in_pin_oe_n)
      else $error("input pin driven outside internal modes");

   xtal_mult_a: assert property (@(posedge core_clk) disable iff (rst)
      xtal_mult_on |-> mode == osm_pkg::fast_crystal_multiplied_mode)
      else $error("crystal multiplier outside code 0110");

   mult_hidden_a: assert property (@(posedge core_clk) disable iff (rst)
      mode_valid && mode == osm_pkg::fast_crystal_multiplied_mode |-> !multiplier_enable_bit)
      else $error("multiplier enable visible in multiplied crystal mode");

   int_mult_gate_a: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      (mult_en_wr && mult_en_wdata && !(role.internal_src && freq_ok)) |=> !mult_en_r)
      else $error("multiplier enable write not ignored");

   // Main scenarios reached
   crystal_start_c: cover property (@(posedge core_clk) role.needs_start && $rose(clk_ready));
   clkout_run_c: cover property (@(posedge core_clk) role.clkout && $rose(osc_out_pin_o));
   int_mult_c: cover property (@(posedge core_clk) $rose(int_mult_on));
   wake_restart_c: cover property (@(posedge core_clk) clk_ready && wake);

endmodule : osm_oscillator_mode_select
`default_nettype wire

// *** include/osm_pkg.sv ***
// Shared constants and types for the oscillator mode select block
`default_nettype none
package osm_pkg;
   // Oscillator modes held after reset
   typedef enum logic [3:0] {
      low_power_crystal_mode,
      standard_crystal_mode,
      fast_crystal_mode,
      fast_crystal_multiplied_mode,
      resistor_capacitor_clkout_mode,
      resistor_capacitor_pin_mode,
      internal_osc_clkout_mode,
      internal_osc_dual_pin_mode,
      external_clock_divout_mode,
      external_clock_pin_mode
   } osm_mode_e;

   // Mode select field width and fixed encodings
   localparam int MODE_W = 4;
   localparam logic [3:0] CODE_FAST_MULT = 4'h6;
   localparam logic [3:0] CODE_INT_DUAL = 4'h8;
   localparam logic [3:0] CODE_INT_CLKOUT = 4'h9;
   // Internal frequency select field and the settings that allow the multiplier
   localparam int FREQ_W = 3;
   localparam logic [2:0] FREQ_MULT_HI = 3'h7;
   localparam logic [2:0] FREQ_MULT_LO = 3'h6;
   // Clock output divides the device clock by this figure
   localparam int CLKOUT_DIV = 4;
   localparam int DIV_W = 2;
   // Multiplier factor and frequency limits in MHz
   localparam int MULT_FACTOR = 4;
   localparam int FAST_XTAL_MAX_MHZ = 10;
   localparam int FAST_MULT_MAX_MHZ = 40;
   localparam int INT_MULT_MAX_MHZ = 32;
   // Edges after reset release before the synchronised field is taken
   localparam logic [1:0] CAP_DELAY = 2'h2;
   // Reset values
   localparam logic [3:0] CFG_RST = 4'h0;
   localparam osm_mode_e MODE_RST = resistor_capacitor_clkout_mode;

   // Pin roles decided by the held mode
   typedef struct packed {
      logic amp_on;        // Amplifier across the two oscillator pins
      logic clkout;        // Output pin carries clock divided by four
      logic out_gpio;      // Output pin is port bit six
      logic in_gpio;       // Input pin is port bit seven
      logic needs_start;   // Crystal start-up wait applies
      logic internal_src;  // Internal oscillator is the source
   } osm_role_s;
endpackage : osm_pkg
`default_nettype wire

// *** verif/osm_osc_partner.sv ***
// Far-side model: crystal, resistor-capacitor network or external clock on the oscillator pins
`timescale 1ns/1ps
`default_nettype none
module osm_osc_partner (
   // Clock and source kind: 0 none, 1 crystal, 2 external clock, 3 resistor-capacitor
   input wire logic core_clk,
   input wire logic [1:0] src_sel,
   input wire logic amp_enable,
   // Device drive of both pins
   input wire logic in_o,
   input wire logic in_oe_n,
   input wire logic out_o,
   input wire logic out_oe_n,
   // Resolved pin levels
   output logic in_lvl,
   output logic out_lvl
);
   logic [2:0] ph_r = 3'h0;
   logic flt_r = 1'b0;
   logic src_in;

   // Source phase; a floating pin toggles so a stale value never reads as valid
   always_ff @(posedge core_clk) begin
      ph_r <= ph_r + 3'h1;
      flt_r <= ~flt_r;
   end

   // What the far side puts on the input pin
   always_comb begin
      case (src_sel)
         2'h1: src_in = amp_enable ? ph_r[1] : flt_r;
         2'h2: src_in = ph_r[2];
         2'h3: src_in = ph_r[0];
         default: src_in = flt_r;
      endcase
   end

   // Device drive wins when enabled; crystal swings the output pin in antiphase
   assign in_lvl = !in_oe_n ? in_o : src_in;
   assign out_lvl = !out_oe_n ? out_o : (src_sel == 2'h1 && amp_enable) ? ~ph_r[1] : flt_r;
endmodule : osm_osc_partner
`default_nettype wire

// *** verif/osm_oscillator_mode_select_bench.sv ***
// Self-checking bench for the oscillator mode select block
`timescale 1ns/1ps
`default_nettype none
module osm_oscillator_mode_select_bench;
   logic core_clk, rst, clk_en, mult_en_wr, mult_en_wdata, wake;
   logic [3:0] mode_cfg;
   logic [2:0] freq;
   logic g6, g6oe_n, g7, g7oe_n;
   logic mv_q = 1'b0;
   logic [1:0] src_sel;
   wire in_i, out_i, in_o, in_oe_n, out_o, out_oe_n, g6_in, g7_in, mv, amp, rdy, xm, im, meb;
   osm_pkg::osm_mode_e mode;
   int bad_count = 0;
   int total_checks = 0;
   logic [4:0] notes[$];

   osm_oscillator_mode_select #(.START_CYCLES(8), .START_W(4)) osm_oscillator_mode_select_i (
      .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .mode_cfg(mode_cfg),
      .internal_freq_select(freq), .mult_en_wr(mult_en_wr), .mult_en_wdata(mult_en_wdata),
      .wake(wake), .gpio6_out(g6), .gpio6_oe_n(g6oe_n), .gpio7_out(g7), .gpio7_oe_n(g7oe_n),
      .osc_in_pin_i(in_i), .osc_out_pin_i(out_i), .osc_in_pin_o(in_o), .osc_in_pin_oe_n(in_oe_n),
      .osc_out_pin_o(out_o), .osc_out_pin_oe_n(out_oe_n), .gpio6_in(g6_in), .gpio7_in(g7_in),
      .mode(mode), .mode_valid(mv), .amp_enable(amp), .clk_ready(rdy), .xtal_mult_on(xm),
      .int_mult_on(im), .multiplier_enable_bit(meb));

   osm_osc_partner osm_osc_partner_i (
      .core_clk(core_clk), .src_sel(src_sel), .amp_enable(amp), .in_o(in_o), .in_oe_n(in_oe_n),
      .out_o(out_o), .out_oe_n(out_oe_n), .in_lvl(in_i), .out_lvl(out_i));

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up

   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check_val

   // Bounded wait on mode_valid (sel 0) or clk_ready (sel 1)
   task automatic wait_for(input logic sel, input int lim);
      for (int n = 0; n < lim; n++) begin
         @(posedge core_clk);
         #1;
         if ((sel ? rdy : mv) === 1'b1) return;
      end
      bad_count++;
      $display("[FAIL] t=%0t wait ran out got %h exp %h", $time, 1'b0, 1'b1);
      wrap_up();
   endtask : wait_for

   // Crystal modes must still be waiting three edges on, the others already ready
   task automatic ready_check(input logic xt);
      repeat (3) @(posedge core_clk);
      #1;
      check_val(16'(rdy), 16'(!xt));
      wait_for(1'b1, 20);
   endtask : ready_check

   task automatic mult_write(input logic d, input logic e);
      @(posedge core_clk);
      mult_en_wr <= 1'b1;
      mult_en_wdata <= d;
      @(posedge core_clk);
      mult_en_wr <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check_val(16'(meb), 16'(e));
      check_val(16'(im), 16'(e));
   endtask : mult_write

   function automatic osm_pkg::osm_mode_e emode(input logic [3:0] c);
      case (c)
         4'h0: return osm_pkg::low_power_crystal_mode;
         4'h1: return osm_pkg::standard_crystal_mode;
         4'h2: return osm_pkg::fast_crystal_mode;
         4'h4: return osm_pkg::external_clock_divout_mode;
         4'h5: return osm_pkg::external_clock_pin_mode;
         4'h6: return osm_pkg::fast_crystal_multiplied_mode;
         4'h7: return osm_pkg::resistor_capacitor_pin_mode;
         4'h8: return osm_pkg::internal_osc_dual_pin_mode;
         4'h9: return osm_pkg::internal_osc_clkout_mode;
         default: return osm_pkg::resistor_capacitor_clkout_mode;
      endcase
   endfunction : emode

   // One mode from reset: decode, start-up, pin roles, clock output, multiplier, hold, wake
   task automatic run_mode(input logic [3:0] c);
      osm_pkg::osm_mode_e m;
      logic xt, ck, og, ig;
      logic [9:0] s;
      m = emode(c);
      xt = c inside {4'h0, 4'h1, 4'h2, 4'h6};
      ck = c inside {4'h3, 4'h4, 4'h9} || c > 4'h9;
      og = c inside {4'h5, 4'h7, 4'h8};
      ig = c inside {4'h8, 4'h9};
      @(posedge core_clk);
      rst <= 1'b1;
      mode_cfg <= c;
      src_sel <= (c inside {4'h0, 4'h1, 4'h6}) ? 2'h1 : (c inside {4'h2, 4'h4, 4'h5}) ? 2'h2 : ig ? 2'h0 : 2'h3;
      {g6, g6oe_n, g7, g7oe_n} <= 4'($urandom);
      freq <= ig ? {2'h3, 1'($urandom)} : 3'($urandom);
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      notes.push_back({m, xt});
      wait_for(1'b0, 10);
      ready_check(xt);
      check_val(16'(out_oe_n), 16'(!(ck || (og && !g6oe_n))));
      if (og && !g6oe_n) check_val(16'({out_o, g6_in}), 16'({g6, g6}));
      if (!og) check_val(16'(g6_in), 16'h0000);
      check_val(16'(in_oe_n), 16'(!(ig && !g7oe_n)));
      if (ig && !g7oe_n) check_val(16'({in_o, g7_in}), 16'({g7, g7}));
      if (!ig) check_val(16'(g7_in), 16'h0000);
      if (ck) begin
         for (int i = 0; i < 10; i++) begin
            @(posedge core_clk);
            #1;
            s[i] = out_o;
         end
         for (int i = 0; i < 8; i++) check_val(16'(s[i] ^ s[i + 2]), 16'h0001);
      end
      // With the enable low the divider and pins stand still; two edges would flip a live output
      @(posedge core_clk);
      clk_en <= 1'b0;
      @(posedge core_clk);
      #1;
      s[0] = out_o;
      repeat (2) @(posedge core_clk);
      #1;
      check_val(16'({out_o, rdy}), 16'({s[0], 1'b1}));
      @(posedge core_clk);
      clk_en <= 1'b1;
      mult_write(1'b1, ig && freq[2:1] == 2'h3);
      check_val(16'(xm), 16'(c == 4'h6));
      if (ig) begin
         // Software can clear the enable and set it again
         mult_write(1'b0, 1'b0);
         mult_write(1'b1, 1'b1);
         // Leaving the allowed frequency drops the enable, and later writes are refused
         @(posedge core_clk);
         freq <= 3'h5;
         repeat (2) @(posedge core_clk);
         #1;
         check_val(16'(meb), 16'h0000);
         mult_write(1'b1, 1'b0);
      end
      @(posedge core_clk);
      mode_cfg <= ~c;
      repeat (4) @(posedge core_clk);
      #1;
      check_val(16'(mode), 16'(m));
      @(posedge core_clk);
      wake <= 1'b1;
      @(posedge core_clk);
      wake <= 1'b0;
      ready_check(xt);
      $display("mode code %h done", c);
   endtask : run_mode

   // Watches for each capture and compares it with the oldest note
   always @(posedge core_clk) begin
      mv_q <= mv;
      if (mv === 1'b1 && mv_q !== 1'b1) begin
         if (notes.size() == 0) check_val(16'h0001, 16'h0000);
         else check_val(16'({mode, amp}), 16'(notes.pop_front()));
      end
   end

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      mode_cfg = 4'h0;
      freq = 3'h0;
      mult_en_wr = 1'b0;
      mult_en_wdata = 1'b0;
      wake = 1'b0;
      {g6, g6oe_n, g7, g7oe_n} = 4'hF;
      src_sel = 2'h0;
      void'($urandom(32'h2ffb));
      for (int k = 0; k < 11; k++) run_mode(4'(k));
      wrap_up();
   end
endmodule : osm_oscillator_mode_select_bench
`default_nettype wire
